// File: core/sfa_pkg.sv
// Shared constants, types and helpers for the serial ADC frame aligner
package sfa_pkg;
   // Bits gathered by one edge deserializer per divided-clock cycle
   localparam int unsigned HALF_W_DEF = 4;
   localparam int unsigned MAX_HALF_W = 6;
   // Divided clock ratio relative to the sampling clock
   localparam int unsigned DIV_RATIO = 4;
   localparam int unsigned CHAN_DEF = 4;
   localparam int unsigned ADC_BITS_DEF = 14;
   localparam logic [11:0] PAT_TWO_WIRE = 12'h0F0;
   localparam logic [11:0] PAT_ONE_WIRE = 12'h0FF;
   localparam logic [1:0] LANES_ONE = 2'h1;
   localparam logic [1:0] LANES_TWO = 2'h2;
   localparam logic ORDER_LSB = 1'h0;
   localparam logic ORDER_MSB = 1'h1;
   localparam logic FMT_BYTE = 1'h0;
   localparam logic FMT_BIT = 1'h1;
   // Divided words discarded after a slip before comparing again
   localparam int unsigned SETTLE_WORDS = 2;
   localparam logic [2:0] CNT_RESET = 3'h0;
   localparam logic [1:0] WAIT_RESET = 2'h0;

   typedef struct packed {
      logic [1:0] lane_count_select;
      logic bit_order_select;
      logic byte_or_bit_format;
   } sfa_cfg_t;

   typedef enum logic [3:0] {
      ST_HUNT = 4'h1,
      ST_SLIP = 4'h2,
      ST_WAIT = 4'h4,
      ST_LOCK = 4'h8
   } sfa_state_t;

   // Interleave: a feeds odd positions, b even positions
   function automatic logic [23:0] weave(input logic [11:0] a, input logic [11:0] b);
      logic [23:0] w;
      w = 24'h000000;
      for (int k = 0; k < 12; k++)
      begin
         w[2*k+1] = a[k];
         w[2*k] = b[k];
      end
      return w;
   endfunction : weave
endpackage : sfa_pkg

// File: core/sfa_lane_deser.sv
// Dual edge deserializer lane with swap multiplexer
`timescale 1ns/10ps
`default_nettype none
module sfa_lane_deser #(
   parameter int unsigned HALF_W = sfa_pkg::HALF_W_DEF
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic rise_bit_i,
   input wire logic fall_bit_i,
   input wire logic load_i,
   input wire logic swap_i,
   output logic [2*HALF_W-1:0] word_o
);
   logic [HALF_W-1:0] rise_q, rise_d, fall_q, fall_d, even_s, odd_s;
   logic [2*HALF_W-1:0] word_q, word_d;
   logic [23:0] woven_s;

   always_comb
   begin
      rise_d = {rise_q[HALF_W-2:0], rise_bit_i}; // RQ2
      fall_d = {fall_q[HALF_W-2:0], ~fall_bit_i}; // RQ4
      even_s = swap_i ? fall_d : rise_d; // RQ6
      odd_s = swap_i ? rise_d : fall_d;
      woven_s = sfa_pkg::weave(12'(even_s), 12'(odd_s));
      word_d = load_i ? woven_s[2*HALF_W-1:0] : word_q; // RQ5
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rise_q <= '0;
         fall_q <= '0;
         word_q <= '0;
      end
      else
      begin
         rise_q <= rise_d;
         fall_q <= fall_d;
         word_q <= word_d;
      end
   end

   assign word_o = word_q;

   chk_fall_inverted: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ4
      (load_i && !swap_i) |=> (word_q[0] == !$past(fall_bit_i)))
      else $error("falling edge bit not inverted");
   chk_even_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ2
      (load_i && !swap_i) |=> (word_q[1] == $past(rise_bit_i)))
      else $error("even bit not from rising edge");
endmodule : sfa_lane_deser
`default_nettype wire

// File: core/sfa_frame_aligner.sv
// Frame aligner: frame lane training, data lanes and word assembly
// Behaviour
// RQ1: Frame lane captured like data by rising and falling edge deserializers.
// RQ2: Rising edge deserializer holds even bits, falling edge the odd bits.
// RQ3: Frame word width is a parameter up to twelve bits.
// RQ4: Falling edge bits are inverted before compare or delivery.
// RQ5: Each completed parallel frame word is compared to the expected pattern; the code skips the SETTLE_WORDS (2) words after each slip.
// RQ6: Swapped pattern also compared; a match enables the swap multiplexer.
// RQ7: No match issues a bitslip; compare and slip repeat until found.
// RQ8: Slip and swap drive every data lane identically to the frame lane.
// RQ9: Data lanes share the capture circuit, no own state machine.
// RQ10: Bits sampled per clock; words handled once per divided cycle.
// RQ11: Sender zero-fills a 14-bit result into a 16-bit word.
// RQ12: One-wire mode: half pattern marks the high byte, next byte low.
// RQ13: One-wire bytes joined by ping-pong registers into one word.
// RQ14: Two-wire mode searches pattern 11110000 on the frame lane.
// RQ15: Each channel in two-wire mode uses two data capture lanes.
// RQ16: Two-wire lanes merged by order and format; stuffing bits dropped.
// RQ17: Sender frame clock is one eighth of bit clock, data aligned.
// RQ18: Sender bit clock is a quarter period off data and frame.
// RQ19: Bit order select: 0 least significant first, 1 most first.
// RQ20: Lane count select: 1 one-wire, 2 two-wire.
// RQ21: Locked flag set on match, held, slips stop until reset.
// RQ22: Data valid only while locked, once per assembled word.
`timescale 1ns/10ps
`default_nettype none
module sfa_frame_aligner #(
   parameter int unsigned NUM_CH = sfa_pkg::CHAN_DEF,
   parameter int unsigned HALF_W = sfa_pkg::HALF_W_DEF,
   parameter int unsigned ADC_BITS = sfa_pkg::ADC_BITS_DEF,
   parameter logic [11:0] PAT_TWO = sfa_pkg::PAT_TWO_WIRE,
   parameter logic [11:0] PAT_ONE = sfa_pkg::PAT_ONE_WIRE
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic frame_rise_i,
   input wire logic frame_fall_i,
   input wire logic [2*NUM_CH-1:0] lane_rise_i,
   input wire logic [2*NUM_CH-1:0] lane_fall_i,
   input wire sfa_pkg::sfa_cfg_t cfg_i,
   output logic locked_o,
   output logic swap_o,
   output logic bitslip_o,
   output logic data_valid_o,
   output logic [NUM_CH-1:0][ADC_BITS-1:0] data_o
);
   localparam int unsigned BYTE_W = 2*HALF_W;
   localparam int unsigned WORD_W = 4*HALF_W;
   localparam int unsigned NLANE = 2*NUM_CH;
   localparam logic [2:0] CNT_LAST = 3'(HALF_W-1);
   localparam logic [1:0] WAIT_LAST = 2'(sfa_pkg::SETTLE_WORDS-1);
   logic rst_meta_q, rst_n_q;
   logic [2:0] cnt_q, cnt_d;
   logic load_s, word_new_q, word_new_d;
   sfa_pkg::sfa_state_t state_q, state_d;
   logic slip_q, slip_d, swap_q, swap_d, locked_q, locked_d;
   logic [1:0] wait_q, wait_d;
   logic [BYTE_W-1:0] frame_word, pat_s, pat_sw_s;
   logic [BYTE_W-1:0] lane_word [NLANE];
   logic match_norm, match_swap, one_wire, msb_flag;
   logic phase_q, phase_d, valid_q, valid_d;
   logic [NUM_CH-1:0][BYTE_W-1:0] msb_q, msb_d;
   logic [NUM_CH-1:0][ADC_BITS-1:0] data_q, data_d;
   sfa_pkg::sfa_cfg_t cfg_one;

   // Merge two bytes by format, order, then drop stuffing bits
   function automatic logic [ADC_BITS-1:0] assemble(input logic [BYTE_W-1:0] hi,
                                                   input logic [BYTE_W-1:0] lo,
                                                   input sfa_pkg::sfa_cfg_t cfg);
      logic [23:0] wv;
      logic [WORD_W-1:0] w, r;
      wv = sfa_pkg::weave(12'(hi), 12'(lo));
      w = (cfg.byte_or_bit_format == sfa_pkg::FMT_BIT) ? wv[WORD_W-1:0] : {hi, lo};
      for (int k = 0; k < WORD_W; k++)
      begin
         r[k] = w[WORD_W-1-k];
      end
      if (cfg.bit_order_select == sfa_pkg::ORDER_LSB) // RQ19
      begin
         w = r;
      end
      return w[WORD_W-1 -: ADC_BITS]; // RQ16
   endfunction : assemble

   // Reset release through two flops
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Divided clock phase; a slip holds it one cycle
   always_comb
   begin
      load_s = (cnt_q == CNT_LAST) && !slip_q; // RQ10
      word_new_d = load_s;
      if (slip_q)
      begin
         cnt_d = cnt_q; // RQ7
      end
      else if (cnt_q == CNT_LAST)
      begin
         cnt_d = sfa_pkg::CNT_RESET;
      end
      else
      begin
         cnt_d = cnt_q + 3'h1;
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         cnt_q <= sfa_pkg::CNT_RESET;
         word_new_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         word_new_q <= word_new_d;
      end
   end

   // Frame lane capture
   sfa_lane_deser #(.HALF_W(HALF_W)) u_frame ( // RQ1 RQ3
      .clock_i(clock_i),
      .rst_n_i(rst_n_q),
      .rise_bit_i(frame_rise_i),
      .fall_bit_i(frame_fall_i),
      .load_i(load_s),
      .swap_i(1'b0),
      .word_o(frame_word)
   );

   // Data lanes, two per channel
   for (genvar i = 0; i < NLANE; i++)
   begin : g_lane
      sfa_lane_deser #(.HALF_W(HALF_W)) u_lane ( // RQ8 RQ9 RQ15
         .clock_i(clock_i),
         .rst_n_i(rst_n_q),
         .rise_bit_i(lane_rise_i[i]),
         .fall_bit_i(lane_fall_i[i]),
         .load_i(load_s),
         .swap_i(swap_q),
         .word_o(lane_word[i])
      );
   end

   // Pattern selection and compare
   always_comb
   begin
      one_wire = (cfg_i.lane_count_select == sfa_pkg::LANES_ONE); // RQ20
      pat_s = one_wire ? PAT_ONE[BYTE_W-1:0] : PAT_TWO[BYTE_W-1:0]; // RQ12 RQ14
      for (int k = 0; k < HALF_W; k++)
      begin
         pat_sw_s[2*k] = pat_s[2*k+1]; // RQ6
         pat_sw_s[2*k+1] = pat_s[2*k];
      end
      match_norm = (frame_word == pat_s); // RQ5
      match_swap = (frame_word == pat_sw_s); // RQ6
   end

   // Alignment state machine
   always_comb
   begin
      state_d = state_q;
      slip_d = 1'b0;
      swap_d = swap_q;
      locked_d = locked_q;
      wait_d = wait_q;
      case (state_q)
         sfa_pkg::ST_HUNT:
         begin
            if (word_new_q)
            begin
               if (match_norm || match_swap)
               begin
                  state_d = sfa_pkg::ST_LOCK; // RQ21
                  locked_d = 1'b1;
                  swap_d = !match_norm; // RQ6
               end
               else
               begin
                  state_d = sfa_pkg::ST_SLIP; // RQ7
                  slip_d = 1'b1;
               end
            end
         end
         sfa_pkg::ST_SLIP:
         begin
            state_d = sfa_pkg::ST_WAIT;
            wait_d = sfa_pkg::WAIT_RESET;
         end
         sfa_pkg::ST_WAIT:
         begin
            if (word_new_q)
            begin
               if (wait_q == WAIT_LAST)
               begin
                  state_d = sfa_pkg::ST_HUNT;
               end
               else
               begin
                  wait_d = wait_q + 2'h1;
               end
            end
         end
         sfa_pkg::ST_LOCK:
         begin
            state_d = sfa_pkg::ST_LOCK; // RQ21
         end
         default:
         begin
            state_d = sfa_pkg::ST_HUNT;
            locked_d = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clock_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= sfa_pkg::ST_HUNT;
         slip_q <= 1'b0;
         swap_q <= 1'b0;
         locked_q <= 1'b0;
         wait_q <= sfa_pkg::WAIT_RESET;
      end
      else
      begin
         state_q <= state_d;
         slip_q <= slip_d;
         swap_q <= swap_d;
         locked_q <= locked_d;
         wait_q <= wait_d;
      end
   end

   // Word assembly
   always_comb
   begin
      cfg_one = cfg_i;
      cfg_one.byte_or_bit_format = sfa_pkg::FMT_BYTE;
      msb_flag = swap_q ? match_swap : match_norm; // RQ12
      valid_d = 1'b0;
      data_d = data_q;
      msb_d = msb_q;
      phase_d = phase_q;
      if (locked_q && word_new_q) // RQ22
      begin
         if (one_wire)
         begin
            if (msb_flag)
            begin
               for (int c = 0; c < NUM_CH; c++)
               begin
                  msb_d[c] = lane_word[c]; // RQ13
               end
               phase_d = 1'b1;
            end
            else if (phase_q)
            begin
               for (int c = 0; c < NUM_CH; c++)
               begin
                  data_d[c] = assemble(msb_q[c], lane_word[c], cfg_one); // RQ13
               end
               valid_d = 1'b1;
               phase_d = 1'b0;
            end
         end
         else
         begin
            for (int c = 0; c < NUM_CH; c++)
            begin
               data_d[c] = assemble(lane_word[2*c], lane_word[2*c+1], cfg_i); // RQ16
            end
            valid_d = 1'b1;
         end
      end
   end
   always_ff @(posedge clock_i or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         phase_q <= 1'b0;
         valid_q <= 1'b0;
         msb_q <= '0;
         data_q <= '0;
      end
      else
      begin
         phase_q <= phase_d;
         valid_q <= valid_d;
         msb_q <= msb_d;
         data_q <= data_d;
      end
   end
   assign locked_o = locked_q;
   assign swap_o = swap_q;
   assign bitslip_o = slip_q;
   assign data_valid_o = valid_q;
   assign data_o = data_q;
   chk_slip_on_miss: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ7
      (state_q == sfa_pkg::ST_HUNT && word_new_q && !match_norm && !match_swap)
      |=> slip_q ##1 (!slip_q && state_q == sfa_pkg::ST_WAIT))
      else $error("missing bitslip after mismatch");
   chk_lock_normal: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ5
      (state_q == sfa_pkg::ST_HUNT && word_new_q && match_norm)
      |=> (locked_q && !swap_q && !slip_q))
      else $error("normal match did not lock unswapped");
   chk_lock_swapped: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ6
      (state_q == sfa_pkg::ST_HUNT && word_new_q && !match_norm && match_swap)
      |=> (locked_q && swap_q))
      else $error("swapped match did not enable swap");
   chk_lock_holds: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ21
      locked_q |=> (locked_q && !slip_q && $stable(swap_q)))
      else $error("lock lost or slip after lock");
   chk_div_period: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ10
      (cnt_q == CNT_LAST && !slip_q) |=> (cnt_q == 3'h0 && word_new_q))
      else $error("divided word strobe out of step");
   chk_valid_locked: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ22
      data_valid_o |-> (locked_q && $past(word_new_q)))
      else $error("data valid without lock");
   chk_one_wire_pair: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ13
      (data_valid_o && cfg_i.lane_count_select == sfa_pkg::LANES_ONE) |-> $past(phase_q))
      else $error("one-wire word without high byte");
   chk_two_wire_rate: assert property (@(posedge clock_i) disable iff (!rst_n_q) // RQ16
      (locked_q && word_new_q && cfg_i.lane_count_select == sfa_pkg::LANES_TWO) |=> data_valid_o)
      else $error("two-wire word not delivered");
endmodule : sfa_frame_aligner
`default_nettype wire

// File: tb/sfa_adc_model.sv
// Behavioural serial converter driving the frame lane and data lanes
`timescale 1ns/10ps
`default_nettype none
module sfa_adc_model #(
   parameter int unsigned NUM_CH = 4
) (
   input wire logic clock_i,
   input wire logic restart_i,
   input wire logic [3:0] offset_i,
   input wire sfa_pkg::sfa_cfg_t cfg_i,
   output logic frame_rise_o,
   output logic frame_fall_o,
   output logic [2*NUM_CH-1:0] lane_rise_o,
   output logic [2*NUM_CH-1:0] lane_fall_o
);
   int pos = 0;

   function automatic logic [13:0] sample_val(input int c, input int n);
      return 14'(32'h0123 + c * 32'h0E51 + n);
   endfunction : sample_val

   function automatic logic [15:0] word16(input int c, input int n);
      logic [15:0] w;
      w = {sample_val(c, n), 2'h0};
      if (cfg_i.bit_order_select == sfa_pkg::ORDER_LSB)
      begin
         w = {<<{w}};
      end
      return w;
   endfunction : word16

   // Bit at stream position p; lane -1 is the frame lane
   function automatic logic bit_at(input int l, input int p);
      logic [15:0] w;
      logic [7:0] b;
      if (cfg_i.lane_count_select == sfa_pkg::LANES_ONE)
      begin
         if (l < 0) return (p % 16) < 8;
         if (l >= int'(NUM_CH)) return (p % 2) == 1;
         w = word16(l, p / 16);
         return w[15 - p % 16];
      end
      if (l < 0) return (p % 8) < 4;
      w = word16(l / 2, p / 8);
      b = (l % 2 == 0) ? w[15:8] : w[7:0];
      if (cfg_i.byte_or_bit_format == sfa_pkg::FMT_BIT)
      begin
         for (int k = 0; k < 8; k++) b[k] = w[2 * k + 1 - l % 2];
      end
      return b[7 - p % 8];
   endfunction : bit_at

   // Bits change between sampling edges
   always @(negedge clock_i)
   begin
      pos = restart_i ? int'(offset_i) : pos + 2;
      frame_rise_o <= bit_at(-1, pos);
      frame_fall_o <= ~bit_at(-1, pos + 1);
      for (int l = 0; l < 2 * NUM_CH; l++)
      begin
         lane_rise_o[l] <= bit_at(l, pos);
         lane_fall_o[l] <= ~bit_at(l, pos + 1);
      end
   end

   initial
   begin
      frame_rise_o = 1'b0;
      frame_fall_o = 1'b1;
      lane_rise_o = '0;
      lane_fall_o = '1;
   end
endmodule : sfa_adc_model
`default_nettype wire

// File: tb/sfa_frame_aligner_tb.sv
// Self-checking bench for the serial converter frame aligner
`timescale 1ns/10ps
`default_nettype none
module sfa_frame_aligner_tb;
   localparam int unsigned NCH = sfa_pkg::CHAN_DEF;
   localparam int unsigned HW = sfa_pkg::HALF_W_DEF;
   logic clock_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic restart = 1'b1;
   logic [3:0] offset = 4'h0;
   sfa_pkg::sfa_cfg_t cfg = '{sfa_pkg::LANES_TWO, sfa_pkg::ORDER_MSB, sfa_pkg::FMT_BYTE};
   logic frame_rise;
   logic frame_fall;
   logic [2*NCH-1:0] lane_rise;
   logic [2*NCH-1:0] lane_fall;
   logic locked;
   logic swap;
   logic bitslip;
   logic data_valid;
   logic [NCH-1:0][sfa_pkg::ADC_BITS_DEF-1:0] data;
   int error_cnt = 0;
   int cmp_count = 0;
   int total_slips = 0;

   always #5 clock_i = ~clock_i;

   sfa_adc_model #(.NUM_CH(NCH)) u_adc (
      .clock_i(clock_i),
      .restart_i(restart),
      .offset_i(offset),
      .cfg_i(cfg),
      .frame_rise_o(frame_rise),
      .frame_fall_o(frame_fall),
      .lane_rise_o(lane_rise),
      .lane_fall_o(lane_fall)
   );

   sfa_frame_aligner #(.NUM_CH(NCH)) DUT (
      .clock_i(clock_i),
      .arst_n_i(arst_n_i),
      .frame_rise_i(frame_rise),
      .frame_fall_i(frame_fall),
      .lane_rise_i(lane_rise),
      .lane_fall_i(lane_fall),
      .cfg_i(cfg),
      .locked_o(locked),
      .swap_o(swap),
      .bitslip_o(bitslip),
      .data_valid_o(data_valid),
      .data_o(data)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %s, seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   // Reset, hunt for the frame, then read six words
   task automatic run_test(input logic [1:0] lanes, input logic order, input logic fmt,
                           input logic [3:0] off);
      int slips, waited, last, per, n, k, nm;
      slips = 0;
      waited = 0;
      last = -100;
      n = 0;
      k = 0;
      per = (lanes == sfa_pkg::LANES_ONE) ? 2 * HW : HW;
      @(negedge clock_i);
      arst_n_i <= 1'b0;
      restart <= 1'b1;
      cfg <= '{lanes, order, fmt};
      offset <= off;
      repeat (4) @(negedge clock_i);
      check(locked, 1'b0, "locked in reset");
      check(data_valid, 1'b0, "valid in reset");
      arst_n_i <= 1'b1;
      restart <= 1'b0;
      while (locked !== 1'b1 && waited < 400)
      begin
         @(negedge clock_i);
         waited++;
         check(data_valid, 1'b0, "valid before lock");
         if (bitslip === 1'b1)
         begin
            check(waited - last >= int'(sfa_pkg::SETTLE_WORDS * HW), 1'b1, "slip gap");
            slips++;
            last = waited;
         end
      end
      check(locked, 1'b1, "no lock");
      check(swap, 1'b0, "swap on symmetric pattern");
      check(slips <= ((lanes == sfa_pkg::LANES_ONE) ? 7 : 3), 1'b1, "slip count");
      total_slips += slips;
      waited = 0;
      while (n < 6 && waited < 100)
      begin
         @(negedge clock_i);
         waited++;
         check(bitslip, 1'b0, "slip after lock");
         check(locked, 1'b1, "lock dropped");
         if (data_valid === 1'b1)
         begin
            if (n == 0)
            begin
               k = int'(14'(data[0] - 14'h0123));
               nm = u_adc.pos / ((lanes == sfa_pkg::LANES_ONE) ? 16 : 8);
               check(k < nm && nm <= k + 3, 1'b1, "word age");
            end
            else
            begin
               check(waited - last, per, "word period");
            end
            for (int c = 0; c < NCH; c++)
            begin
               check(data[c], u_adc.sample_val(c, k + n), "channel word");
            end
            last = waited;
            n++;
         end
      end
      check(n, 6, "word count");
      $display("test done: lanes %0d order %0d format %0d offset %0d", lanes, order, fmt, off);
   endtask : run_test

   initial
   begin
      run_test(sfa_pkg::LANES_TWO, sfa_pkg::ORDER_MSB, sfa_pkg::FMT_BYTE, 4'h0);
      run_test(sfa_pkg::LANES_TWO, sfa_pkg::ORDER_LSB, sfa_pkg::FMT_BYTE, 4'h2);
      run_test(sfa_pkg::LANES_TWO, sfa_pkg::ORDER_MSB, sfa_pkg::FMT_BIT, 4'h4);
      run_test(sfa_pkg::LANES_TWO, sfa_pkg::ORDER_LSB, sfa_pkg::FMT_BIT, 4'h6);
      run_test(sfa_pkg::LANES_ONE, sfa_pkg::ORDER_MSB, sfa_pkg::FMT_BYTE, 4'h0);
      run_test(sfa_pkg::LANES_ONE, sfa_pkg::ORDER_LSB, sfa_pkg::FMT_BYTE, 4'hA);
      check(total_slips > 0, 1'b1, "no slip seen");
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      report_and_stop();
   end
endmodule : sfa_frame_aligner_tb
`default_nettype wire
